// ==== verilog/dbt_timer.sv ====
`timescale 1ns/100ps
module dbt_timer (
   // Clock and reset
   input  wire logic                        ref_clk_in,
   input  wire logic                        rst_n_in,
   // SFR access
   input  wire logic [dbt_pkg::SFR_AW-1:0]  sfr_addr_in,
   input  wire logic                        sfr_wr_in,
   input  wire logic                        sfr_rd_in,
   input  wire logic [dbt_pkg::SFR_DW-1:0]  sfr_wdata_in,
   output logic      [dbt_pkg::SFR_DW-1:0]  sfr_rdata_out,
   // Mode and clock selection
   input  wire logic                        run_in,
   input  wire logic                        eight_bit_mode_in,
   input  wire logic                        low_clock_select_in,
   input  wire logic                        high_clock_select_in,
   input  wire logic                        ext_clock_select_in,
   input  wire logic                        capture_enable_in,
   // External oscillator
   input  wire logic                        ext_clk_in,
   // Reload pair loading by software
   input  wire logic                        reload_wr_in,
   input  wire logic [dbt_pkg::SFR_DW-1:0]  reload_high_in,
   input  wire logic [dbt_pkg::SFR_DW-1:0]  reload_low_in,
   output logic      [dbt_pkg::SFR_DW-1:0]  reload_high_out,
   output logic      [dbt_pkg::SFR_DW-1:0]  reload_low_out,
   // Flags and interrupt
   input  wire logic                        timer_irq_en_in,
   input  wire logic                        low_overflow_irq_en_in,
   input  wire logic                        high_flag_clr_in,
   input  wire logic                        low_flag_clr_in,
   output logic                             high_overflow_flag_out,
   output logic                             low_overflow_flag_out,
   output logic                             irq_out
);
   import dbt_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   localparam int unsigned DW = SFR_DW;

   dbt_byte_if #(.W(DW)) low_if ();
   dbt_byte_if #(.W(DW)) high_if ();

   logic [SYS_DIV_W-1:0] div12_q;
   logic                 div12_pulse;
   logic                 ext_meta_q;
   logic                 ext_sync_q;
   logic                 ext_prev_q;
   logic                 ext_rise;
   logic [EXT_DIV_W-1:0] ext_cnt_q;
   logic                 ext8_fall;
   logic                 slow_tick;
   logic                 low_src_tick;
   logic                 high_src_tick;
   logic                 mode16;
   logic                 cap_evt;
   logic                 wr_low;
   logic                 wr_high;
   logic                 reload16;
   logic [DW-1:0]        reload_high_q;
   logic [DW-1:0]        reload_low_q;
   logic                 high_flag_q;
   logic                 high_flag_d;
   logic                 low_flag_q;
   logic                 low_flag_d;
   logic                 irq_q;
   logic                 irq_d;
   logic [DW-1:0]        rdata_q;
   logic [DW-1:0]        rdata_d;

   ////////////////////////////////////////////////////////////////////////////
   // Prescalers

   // System clock / 12 enable
   assign div12_pulse = (div12_q == SYS_DIV_W'(SYS_DIV - 1));

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div12_q <= '0;
      end else begin
         div12_q <= div12_pulse ? '0 : div12_q + SYS_DIV_W'(1);
      end
   end

   // External clock: first flop feeds only the second
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ext_meta_q <= 1'b0;
         ext_sync_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end else begin
         ext_meta_q <= ext_clk_in;
         ext_sync_q <= ext_meta_q;
         ext_prev_q <= ext_sync_q;
      end
   end

   // Divide by 8; bit 2 falls as the count wraps 7 to 0
   assign ext_rise  = ext_sync_q && !ext_prev_q;
   assign ext8_fall = ext_rise && (ext_cnt_q == EXT_DIV_W'(EXT_DIV - 1));

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ext_cnt_q <= '0;
      end else if (ext_rise) begin
         ext_cnt_q <= ext_cnt_q + EXT_DIV_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter byte control

   // Per-byte clock source select
   assign slow_tick     = ext_clock_select_in ? ext8_fall : div12_pulse;
   assign low_src_tick  = run_in && (low_clock_select_in || slow_tick);
   assign high_src_tick = run_in && (high_clock_select_in || slow_tick);
   assign mode16        = !eight_bit_mode_in;
   assign cap_evt       = capture_enable_in && ext8_fall;

   // SFR writes to the counter bytes
   assign wr_low  = sfr_wr_in && (sfr_addr_in == OFS_COUNT_LOW);
   assign wr_high = sfr_wr_in && (sfr_addr_in == OFS_COUNT_HIGH);

   // Full 16-bit overflow reloads the pair unless capturing
   assign reload16 = mode16 && high_if.wrap && !capture_enable_in;

   // Low byte: same clock in both modes
   assign low_if.tick       = low_src_tick;
   assign low_if.wr         = wr_low;
   assign low_if.wr_data    = sfr_wdata_in;
   assign low_if.reload_val = reload_low_q;
   assign low_if.reload     = capture_enable_in ? 1'b0 :
                              mode16 ? reload16 : low_if.wrap;

   // High byte: carry from low in 16-bit, own clock in 8-bit
   assign high_if.tick       = mode16 ? low_if.wrap : high_src_tick;
   assign high_if.wr         = wr_high;
   assign high_if.wr_data    = sfr_wdata_in;
   assign high_if.reload_val = reload_high_q;
   assign high_if.reload     = capture_enable_in ? 1'b0 :
                               mode16 ? reload16 : high_if.wrap;

   dbt_byte #(.W(DW)) u_low (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .bus        (low_if.cnt)
   );

   dbt_byte #(.W(DW)) u_high (
      .ref_clk_in (ref_clk_in),
      .rst_n_in   (rst_n_in),
      .bus        (high_if.cnt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Reload pair and capture

   // Capture beats a software load in the same cycle, keeping the measurement
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         reload_high_q <= RELOAD_RESET;
         reload_low_q  <= RELOAD_RESET;
      end else if (cap_evt) begin
         reload_high_q <= high_if.count;
         reload_low_q  <= low_if.count;
      end else if (reload_wr_in) begin
         reload_high_q <= reload_high_in;
         reload_low_q  <= reload_low_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flags and interrupt

   // Set wins over a clear in the same cycle; no hardware clear exists
   assign high_flag_d = high_if.wrap || cap_evt || (high_flag_q && !high_flag_clr_in);
   assign low_flag_d  = low_if.wrap || (low_flag_q && !low_flag_clr_in);
   assign irq_d       = timer_irq_en_in &&
                        (high_flag_d || (low_overflow_irq_en_in && low_flag_d));

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         high_flag_q <= 1'b0;
         low_flag_q  <= 1'b0;
         irq_q       <= 1'b0;
      end else begin
         high_flag_q <= high_flag_d;
         low_flag_q  <= low_flag_d;
         irq_q       <= irq_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // SFR read port

   // Read data is registered, so it trails the strobe by one cycle
   assign rdata_d = !sfr_rd_in                       ? rdata_q       :
                    (sfr_addr_in == OFS_COUNT_LOW)  ? low_if.count  :
                    (sfr_addr_in == OFS_COUNT_HIGH) ? high_if.count :
                    RDATA_RESET;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_q <= RDATA_RESET;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign sfr_rdata_out          = rdata_q;
   assign reload_high_out        = reload_high_q;
   assign reload_low_out         = reload_low_q;
   assign high_overflow_flag_out = high_flag_q;
   assign low_overflow_flag_out  = low_flag_q;
   assign irq_out                = irq_q;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   property p_high_flag_wrap;
      high_if.wrap && !wr_high && !high_if.reload |=> high_flag_q && high_if.count == 8'h00;
   endproperty
   a_high_flag_wrap: assert property (p_high_flag_wrap)
      else $error("high flag not set on high byte rollover");

   property p_low_flag_wrap;
      low_if.wrap && !wr_low && !low_if.reload |=> low_flag_q && low_if.count == 8'h00;
   endproperty
   a_low_flag_wrap: assert property (p_low_flag_wrap)
      else $error("low flag not set on low byte rollover");

   property p_irq_high;
      timer_irq_en_in && high_if.wrap |=> irq_q;
   endproperty
   a_irq_high: assert property (p_irq_high)
      else $error("no interrupt on high overflow");

   property p_irq_low;
      timer_irq_en_in && low_overflow_irq_en_in && low_if.wrap |=> irq_q;
   endproperty
   a_irq_low: assert property (p_irq_low)
      else $error("no interrupt on low overflow");

   property p_irq_low_masked;
      !timer_irq_en_in || (!low_overflow_irq_en_in && !high_flag_d) |=> !irq_q;
   endproperty
   a_irq_low_masked: assert property (p_irq_low_masked)
      else $error("interrupt raised while masked");

   property p_flags_sticky;
      high_flag_q && low_flag_q && !high_flag_clr_in && !low_flag_clr_in
         |=> high_flag_q && low_flag_q;
   endproperty
   a_flags_sticky: assert property (p_flags_sticky)
      else $error("overflow flag cleared without software");

   property p_div12_spacing;
      div12_pulse |=> !div12_pulse [*8] ##1 !div12_pulse [*3] ##1 div12_pulse;
   endproperty
   a_div12_spacing: assert property (p_div12_spacing)
      else $error("system clock divide by 12 spacing wrong");

   property p_capture_copy;
      cap_evt |=> reload_high_q == $past(high_if.count) &&
                  reload_low_q == $past(low_if.count) && high_flag_q;
   endproperty
   a_capture_copy: assert property (p_capture_copy)
      else $error("capture did not copy count or set flag");

   property p_capture_edge;
      cap_evt |-> ext_rise && ext_cnt_q == 3'h7 && capture_enable_in;
   endproperty
   a_capture_edge: assert property (p_capture_edge)
      else $error("capture outside external divide by 8 falling edge");

   property p_low_readback;
      sfr_rd_in && sfr_addr_in == OFS_COUNT_LOW |=> sfr_rdata_out == $past(low_if.count);
   endproperty
   a_low_readback: assert property (p_low_readback)
      else $error("low byte read data wrong");

   property p_split_hold;
      eight_bit_mode_in && !high_src_tick && !wr_high |=> $stable(high_if.count);
   endproperty
   a_split_hold: assert property (p_split_hold)
      else $error("high byte moved without its own clock in 8-bit mode");

   property p_carry16;
      mode16 && low_if.wrap && !high_if.wrap && !wr_high
         |=> high_if.count == $past(high_if.count) + 8'h01;
   endproperty
   a_carry16: assert property (p_carry16)
      else $error("low overflow not carried into high byte");

   property p_reload16;
      reload16 && !wr_low && !wr_high
         |=> low_if.count == $past(reload_low_q) && high_if.count == $past(reload_high_q);
   endproperty
   a_reload16: assert property (p_reload16)
      else $error("16-bit overflow did not reload");

   property p_capture_no_reload;
      capture_enable_in && high_if.wrap && !wr_high |=> high_if.count == 8'h00;
   endproperty
   a_capture_no_reload: assert property (p_capture_no_reload)
      else $error("reload happened in capture mode");

   c_capture:  cover property (cap_evt ##1 high_flag_q);
   c_reload16: cover property (reload16 ##1 irq_q);
   c_split:    cover property (eight_bit_mode_in && low_if.wrap && high_if.wrap);
   c_clr_set:  cover property (high_flag_clr_in && high_if.wrap);
endmodule

// ==== verilog/dbt_pkg.sv ====
package dbt_pkg;
   // SFR port geometry
   localparam int unsigned SFR_AW = 8;
   localparam int unsigned SFR_DW = 8;

   // SFR addresses of the counter bytes
   localparam logic [SFR_AW-1:0] OFS_COUNT_LOW  = 8'hcc;
   localparam logic [SFR_AW-1:0] OFS_COUNT_HIGH = 8'hcd;

   // Reset values
   localparam logic [SFR_DW-1:0] COUNT_RESET  = 8'h00;
   localparam logic [SFR_DW-1:0] RELOAD_RESET = 8'h00;
   localparam logic [SFR_DW-1:0] RDATA_RESET  = 8'h00;

   // Counter byte extremes
   localparam logic [SFR_DW-1:0] BYTE_MAX = 8'hff;

   // Prescaler ratios: system clock / 12, external clock / 8
   localparam int unsigned SYS_DIV = 12;
   localparam int unsigned EXT_DIV = 8;
   localparam int unsigned SYS_DIV_W = $clog2(SYS_DIV);
   localparam int unsigned EXT_DIV_W = $clog2(EXT_DIV);
endpackage

// ==== verilog/dbt_byte_if.sv ====
`timescale 1ns/100ps
// Control and status of one counter byte
interface dbt_byte_if #(parameter int unsigned W = 8);
   logic         tick;
   logic         wr;
   logic [W-1:0] wr_data;
   logic         reload;
   logic [W-1:0] reload_val;
   logic [W-1:0] count;
   logic         wrap;

   modport ctrl (output tick, wr, wr_data, reload, reload_val, input count, wrap);
   modport cnt  (input tick, wr, wr_data, reload, reload_val, output count, wrap);
endinterface

// ==== verilog/dbt_byte.sv ====
`timescale 1ns/100ps
module dbt_byte #(
   parameter int unsigned W = 8
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Byte control
   dbt_byte_if.cnt  bus
);
   import dbt_pkg::*;

   logic [W-1:0] count_q;
   logic [W-1:0] count_d;

   // Software write beats reload, reload beats counting
   assign count_d = bus.wr     ? bus.wr_data    :
                    bus.reload ? bus.reload_val :
                    bus.tick   ? count_q + W'(1) : count_q;

   // Rolls over to zero on the tick after the all-ones value
   assign bus.wrap  = bus.tick && (count_q == {W{1'b1}});
   assign bus.count = count_q;

   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count_q <= W'(COUNT_RESET);
      end else begin
         count_q <= count_d;
      end
   end
endmodule

// ==== test/dbt_timer_tb_top.sv ====
`timescale 1ns/100ps
module dbt_timer_tb_top;
   import dbt_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   // Stimulus and observed signals
   logic              ref_clk_in, rst_n_in, sfr_wr_in, sfr_rd_in;
   logic [SFR_AW-1:0] sfr_addr_in;
   logic [SFR_DW-1:0] sfr_wdata_in, sfr_rdata_out, rd_lo, rd_hi;
   logic              run_in, eight_bit_mode_in, low_clock_select_in;
   logic              high_clock_select_in, ext_clock_select_in, capture_enable_in;
   logic              ext_clk_in, reload_wr_in, timer_irq_en_in, low_overflow_irq_en_in;
   logic              high_flag_clr_in, low_flag_clr_in;
   logic [SFR_DW-1:0] reload_high_in, reload_low_in, reload_high_out, reload_low_out;
   logic              high_overflow_flag_out, low_overflow_flag_out, irq_out;
   int                err_count;
   int                n_compared;

   dbt_timer DUT (
      .ref_clk_in             (ref_clk_in),
      .rst_n_in               (rst_n_in),
      .sfr_addr_in            (sfr_addr_in),
      .sfr_wr_in              (sfr_wr_in),
      .sfr_rd_in              (sfr_rd_in),
      .sfr_wdata_in           (sfr_wdata_in),
      .sfr_rdata_out          (sfr_rdata_out),
      .run_in                 (run_in),
      .eight_bit_mode_in      (eight_bit_mode_in),
      .low_clock_select_in    (low_clock_select_in),
      .high_clock_select_in   (high_clock_select_in),
      .ext_clock_select_in    (ext_clock_select_in),
      .capture_enable_in      (capture_enable_in),
      .ext_clk_in             (ext_clk_in),
      .reload_wr_in           (reload_wr_in),
      .reload_high_in         (reload_high_in),
      .reload_low_in          (reload_low_in),
      .reload_high_out        (reload_high_out),
      .reload_low_out         (reload_low_out),
      .timer_irq_en_in        (timer_irq_en_in),
      .low_overflow_irq_en_in (low_overflow_irq_en_in),
      .high_flag_clr_in       (high_flag_clr_in),
      .low_flag_clr_in        (low_flag_clr_in),
      .high_overflow_flag_out (high_overflow_flag_out),
      .low_overflow_flag_out  (low_overflow_flag_out),
      .irq_out                (irq_out)
   );

   // 100 MHz system clock
   initial ref_clk_in = 1'b0;
   always #5 ref_clk_in = ~ref_clk_in;

   ////////////////////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Every drive lands just after an edge, never on it
   task automatic nxt();
      @(posedge ref_clk_in);
      #1;
   endtask

   task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
      nxt();
      sfr_addr_in = a;
      sfr_wdata_in = d;
      sfr_wr_in = 1'b1;
      nxt();
      sfr_wr_in = 1'b0;
   endtask

   // Read data is registered: valid after the strobe's edge
   task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
      nxt();
      sfr_addr_in = a;
      sfr_rd_in = 1'b1;
      nxt();
      sfr_rd_in = 1'b0;
      d = sfr_rdata_out;
   endtask

   task automatic set_count(input logic [15:0] v);
      sfr_write(OFS_COUNT_LOW, v[7:0]);
      sfr_write(OFS_COUNT_HIGH, v[15:8]);
   endtask

   task automatic get_count();
      sfr_read(OFS_COUNT_LOW, rd_lo);
      sfr_read(OFS_COUNT_HIGH, rd_hi);
   endtask

   // Exactly n sampled edges with run high
   task automatic run_for(input int n);
      nxt();
      run_in = 1'b1;
      repeat (n) @(posedge ref_clk_in);
      #1;
      run_in = 1'b0;
   endtask

   task automatic load_reload(input logic [7:0] h, input logic [7:0] l);
      nxt();
      reload_high_in = h;
      reload_low_in = l;
      reload_wr_in = 1'b1;
      nxt();
      reload_wr_in = 1'b0;
   endtask

   task automatic clr_flags();
      nxt();
      high_flag_clr_in = 1'b1;
      low_flag_clr_in = 1'b1;
      nxt();
      high_flag_clr_in = 1'b0;
      low_flag_clr_in = 1'b0;
   endtask

   // Oscillator of 8 system cycles, slow enough for the synchroniser
   task automatic ext_pulses(input int n);
      repeat (n) begin
         ext_clk_in = 1'b1;
         repeat (4) @(posedge ref_clk_in);
         #1;
         ext_clk_in = 1'b0;
         repeat (4) @(posedge ref_clk_in);
         #1;
      end
   endtask

   task automatic set_mode(input logic e8, input logic ls, input logic hs, input logic xs);
      eight_bit_mode_in = e8;
      low_clock_select_in = ls;
      high_clock_select_in = hs;
      ext_clock_select_in = xs;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset_and_sfr();
      get_count();
      chk("low count reset", 16'h0000, rd_lo);
      chk("high count reset", 16'h0000, rd_hi);
      chk("flags irq reset", 16'h0000, {high_overflow_flag_out, low_overflow_flag_out, irq_out});
      sfr_write(8'h10, 8'hff);
      set_count(16'ha55a);
      get_count();
      chk("count readback", 16'ha55a, {rd_hi, rd_lo});
      sfr_read(8'h10, rd_lo);
      chk("unmapped read", 16'h0000, rd_lo);
   endtask

   task automatic t_carry_16();
      set_mode(1'b0, 1'b1, 1'b0, 1'b0);
      timer_irq_en_in = 1'b1;
      load_reload(8'h12, 8'h34);
      set_count(16'h01ff);
      run_for(1);
      chk("low flag", 16'h0001, low_overflow_flag_out);
      chk("high flag", 16'h0000, high_overflow_flag_out);
      repeat (2) nxt();
      chk("irq low masked", 16'h0000, irq_out);
      low_overflow_irq_en_in = 1'b1;
      repeat (3) nxt();
      chk("irq low enabled", 16'h0001, irq_out);
      get_count();
      chk("carry count", 16'h0200, {rd_hi, rd_lo});
      clr_flags();
      repeat (2) nxt();
      chk("cleared irq", 16'h0000, {low_overflow_flag_out, irq_out});
      low_overflow_irq_en_in = 1'b0;
      set_count(16'hffff);
      run_for(1);
      chk("high flag wrap", 16'h0001, high_overflow_flag_out);
      repeat (20) nxt();
      chk("high flag sticky", 16'h0001, high_overflow_flag_out);
      chk("irq high", 16'h0001, irq_out);
      get_count();
      chk("full wrap reload", 16'h1234, {rd_hi, rd_lo});
      clr_flags();
      chk("high flag clear", 16'h0000, high_overflow_flag_out);
   endtask

   task automatic t_eight_bit();
      set_mode(1'b1, 1'b1, 1'b0, 1'b0);
      set_count(16'h0000);
      run_for(24);
      get_count();
      chk("low sys_clk_src", 16'h0018, rd_lo);
      chk("high div12", 16'h0002, rd_hi);
      set_mode(1'b1, 1'b0, 1'b1, 1'b1);
      set_count(16'h0000);
      nxt();
      run_in = 1'b1;
      ext_pulses(16);
      repeat (6) nxt();
      run_in = 1'b0;
      get_count();
      chk("low ext div8", 16'h0002, rd_lo);
      set_mode(1'b1, 1'b1, 1'b1, 1'b0);
      load_reload(8'hab, 8'hcd);
      set_count(16'h10ff);
      run_for(1);
      chk("low flag 8bit", 16'h0001, low_overflow_flag_out);
      chk("high flag 8bit", 16'h0000, high_overflow_flag_out);
      get_count();
      chk("own byte reload", 16'h11cd, {rd_hi, rd_lo});
      clr_flags();
   endtask

   task automatic t_capture();
      // 16-bit mode with the timer on the full system clock
      set_mode(1'b0, 1'b1, 1'b0, 1'b0);
      load_reload(8'h5a, 8'ha5);
      nxt();
      ext_pulses(8);
      repeat (6) nxt();
      chk("no capture off", 16'h5aa5, {reload_high_out, reload_low_out});
      chk("no flag off", 16'h0000, high_overflow_flag_out);
      capture_enable_in = 1'b1;
      set_count(16'h0000);
      nxt();
      run_in = 1'b1;
      ext_pulses(8);
      repeat (8) nxt();
      run_in = 1'b0;
      // Eighth rise passes sync and edge detect 58 ticks into the run
      chk("capture value", 16'h003a, {reload_high_out, reload_low_out});
      chk("capture flag", 16'h0001, high_overflow_flag_out);
      chk("capture irq", 16'h0001, irq_out);
      get_count();
      chk("free run count", 16'h0048, {rd_hi, rd_lo});
      clr_flags();
      ext_pulses(8);
      repeat (6) nxt();
      chk("capture held count", 16'h0048, {reload_high_out, reload_low_out});
      chk("capture flag again", 16'h0001, high_overflow_flag_out);
      capture_enable_in = 1'b0;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      err_count = 0;
      n_compared = 0;
      rst_n_in = 1'b0;
      {sfr_wr_in, sfr_rd_in, run_in, capture_enable_in, ext_clk_in, reload_wr_in} = 6'h00;
      {timer_irq_en_in, low_overflow_irq_en_in, high_flag_clr_in, low_flag_clr_in} = 4'h0;
      set_mode(1'b0, 1'b0, 1'b0, 1'b0);
      sfr_addr_in = 8'h00;
      sfr_wdata_in = 8'h00;
      reload_high_in = 8'h00;
      reload_low_in = 8'h00;
      repeat (20) @(posedge ref_clk_in);
      #1;
      rst_n_in = 1'b1;
      t_reset_and_sfr();
      t_carry_16();
      t_eight_bit();
      t_capture();
      complete_run();
   end

   // Whole run is about 500 cycles; cut off far beyond that
   initial begin
      #100000;
      err_count++;
      complete_run();
   end
endmodule
